// file: core/cam_lookup_map.vh
`ifndef CAM_LOOKUP_MAP_VH
`define CAM_LOOKUP_MAP_VH
// Entry geometry and partition limits.
`define ENTRY_W          80
`define CMP_W_MIN        7'h20
`define CMP_W_MAX        7'h50
`define ENTRY_ONES       80'hffff_ffff_ffff_ffff_ffff
// Port width selection: both configuration bits set selects 32-bit lanes.
`define PORT_WIDE        2'h3
`define LANE_16          7'h10
`define LANE_32          7'h20
// Opcodes for the synchronous port and the host command register.
`define OP_LOAD          4'h1
`define OP_SEARCH        4'h2
`define OP_LEARN         4'h3
`define OP_AGE           4'h4
`define OP_CLR_LQ        4'h5
`define OP_CLR_AQ        4'h6
// Host register indices, taken from host_reg_addr bits 5 to 1.
`define REG_STATUS       5'h00
`define REG_INDEX        5'h01
`define REG_FLAG_AQ      5'h02
`define REG_FLAG_LQ      5'h03
`define REG_FLAG_HOST_WRITE_EXCEPTION    5'h04
`define REG_FLAG_SYNC_WRITE_EXCEPTION    5'h05
`define REG_IMG0         5'h06
`define REG_IMG1         5'h07
`define REG_IMG2         5'h08
`define REG_CMD          5'h09
`define REG_RESULT       5'h0a
// Interrupt source bit positions.
`define INT_AQ           0
`define INT_LQ           1
`define INT_HOST_WRITE_EXCEPTION         2
`define INT_SYNC_WRITE_EXCEPTION         3
// Clock periods the input-ready output stays low after reset release.
`define READY_DELAY_CLKS 800
// Free entries at which a colliding lower-priority learn is refused.
`define EXC_FREE_LEFT    2
`endif

// file: core/cam_lookup_dual_port_interface.v
// What this block does
// - One search plus one learn completes within seven clock periods.
// - Entries are 80 bits, compare width programmable from 32 to 80 bits.
// - Searches compare only the compare partition; the rest is returned data.
// - Both ports run concurrently; the configured priority port wins database collisions.
// - Synchronous port lanes are 16 or 32 bits, chosen by two configuration bits.
// - Results leave on the output bus with a valid strobe, coincident or leading.
// - A search hit returns associated data and index, order configurable.
// - An external output enable puts the synchronous output bus in high impedance.
// - Each output-advance pulse presents the next word of wide results.
// - Host register index is address bits 5 to 1; bit 0 picks a half.
// - Host ready rises when read data is valid or write data was taken.
// - Match flag goes low when the previous search or learn hit.
// - Full flag goes low when no entry is free for learning.
// - Up to four devices chain through cascade signals without configuration.
// - Interrupt output polarity is configurable.
// - Four enableable interrupt sources: both queues and both write exceptions.
// - All reads and writes are registered on the single system clock.
// - Input-ready stays low for up to 800 clocks after reset release.
// - Flag read acknowledges; queue interrupt rearms only after the queue empties.
// - A colliding lower-priority host access keeps host ready low until done.
`timescale 1ns/10ps
`default_nettype none
`include "cam_lookup_map.vh"
module cam_lookup_dual_port_interface #(
    parameter DEPTH       = 8,
    parameter IDX_W       = 3,
    parameter READY_DELAY = `READY_DELAY_CLKS
) (
    input  wire        clk,
    input  wire        reset,
    input  wire [1:0]  cfg_port_width,
    input  wire [6:0]  cfg_cmp_width,
    input  wire        cfg_sync_priority,
    input  wire        cfg_valid_lead,
    input  wire        cfg_index_first,
    input  wire        cfg_host_wide,
    input  wire        cfg_int_active_high,
    input  wire [3:0]  cfg_int_enable,
    input  wire [31:0] din,
    input  wire        sync_in_strobe_n,
    input  wire [3:0]  opcode_in,
    output wire        sync_in_ready,
    output reg  [31:0] dout,
    output wire        dout_oe,
    input  wire        out_enable_n,
    output wire        sync_out_valid_n,
    input  wire        sync_out_advance_n,
    input  wire [5:0]  host_reg_addr,
    input  wire        host_rw,
    input  wire        host_select_n,
    input  wire [31:0] host_data_in,
    output reg  [31:0] host_data_out,
    output wire        host_data_oe,
    output reg         host_ack,
    output wire        match_flag_n,
    output wire        full_flag_n,
    output reg         int_out,
    input  wire        cascade_down,
    output wire        cascade_up,
    output wire        cascade_select,
    output wire [3:0]  cascade_bus
);
    localparam ST_IDLE = 3'b001;
    localparam ST_CMP  = 3'b010;
    localparam ST_RES  = 3'b100;

    // Pin inputs, active-low ones inverted first, pass two flip-flops.
    localparam PIN_W = 80;
    wire [PIN_W-1:0] pin_raw = {host_data_in, host_reg_addr, host_rw, ~host_select_n, ~out_enable_n,
                                ~sync_out_advance_n, ~sync_in_strobe_n, opcode_in, din, cascade_down};
    reg  [PIN_W-1:0] pin_meta_reg;
    reg  [PIN_W-1:0] pin_sync_reg;
    always @(posedge clk) begin
        if (reset) begin
            pin_meta_reg <= {PIN_W{1'b0}};
            pin_sync_reg <= {PIN_W{1'b0}};
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end
    wire        casc_s = pin_sync_reg[0];
    wire [31:0] din_s  = pin_sync_reg[32:1];
    wire [3:0]  op_s   = pin_sync_reg[36:33];
    wire        stb_s  = pin_sync_reg[37];
    wire        adv_s  = pin_sync_reg[38];
    wire        oe_s   = pin_sync_reg[39];
    wire        sel_s  = pin_sync_reg[40];
    wire        rw_s   = pin_sync_reg[41];
    wire [5:0]  addr_s = pin_sync_reg[47:42];
    wire [31:0] hdin_s = pin_sync_reg[79:48];

    // Compare width clamped into the legal partition range.
    function [6:0] clamp_cw(input [6:0] w);
        clamp_cw = (w < `CMP_W_MIN) ? `CMP_W_MIN : ((w > `CMP_W_MAX) ? `CMP_W_MAX : w);
    endfunction
    // Sixteen-bit host accesses update only the half selected by address bit 0.
    function [31:0] merge_half(input [31:0] old, input [31:0] nw, input half, input wide);
        merge_half = wide ? nw : (half ? {nw[15:0], old[15:0]} : {old[31:16], nw[15:0]});
    endfunction

    wire        lane_wide = (cfg_port_width == `PORT_WIDE);
    wire [6:0]  lane_w    = lane_wide ? `LANE_32 : `LANE_16;
    wire [6:0]  cw        = clamp_cw(cfg_cmp_width);
    wire [79:0] kmask     = ~(`ENTRY_ONES << cw);
    wire [6:0]  assoc_w   = `CMP_W_MAX - cw;
    wire [6:0]  n_assoc   = lane_wide ? ((assoc_w + 7'h1f) >> 5) : ((assoc_w + 7'h0f) >> 4);

    reg  [79:0]      entry_mem [0:DEPTH-1];
    reg  [DEPTH-1:0] valid_reg;
    reg  [2:0]       state_reg;
    reg  [9:0]       init_cnt_reg;
    reg  [111:0]     cmp_buf_reg;
    reg  [6:0]       load_pos_reg;
    reg              sync_pend_reg;
    reg  [3:0]       sync_op_reg;
    reg  [31:0]      sync_assoc_reg;
    reg              host_pend_reg;
    reg  [3:0]       host_op_reg;
    reg  [31:0]      img0_reg, img1_reg, img2_reg;
    reg              cur_host_reg;
    reg  [3:0]       cur_op_reg;
    reg  [79:0]      cur_img_reg;
    reg              hit_reg, match_reg;
    reg  [IDX_W-1:0] hit_idx_reg, free_idx_reg, res_idx_reg;
    reg              free_any_reg;
    reg  [79:0]      res_assoc_reg;
    reg  [2:0]       out_cnt_reg;
    reg  [2:0]       out_total_reg;
    reg              adv_prev_reg;
    reg  [31:0]      stage_reg;
    reg              stage_vld_reg, dvld_reg;
    reg  [7:0]       lq_cnt_reg, aq_cnt_reg;
    reg              lq_armed_reg, aq_armed_reg;
    reg  [3:0]       pend_int_reg;
    reg              host_act_reg, host_cmd_wait_reg;

    wire init_done = (init_cnt_reg == READY_DELAY[9:0]);

    // Associative compare and free-entry search over all entries at once.
    reg  [IDX_W-1:0] c_hit_idx, c_free_idx;
    reg              c_hit, c_free;
    reg  [IDX_W:0]   c_free_cnt;
    integer i;
    always @* begin
        c_hit = 1'b0;
        c_free = 1'b0;
        c_hit_idx = {IDX_W{1'b0}};
        c_free_idx = {IDX_W{1'b0}};
        c_free_cnt = {(IDX_W+1){1'b0}};
        for (i = DEPTH-1; i >= 0; i = i - 1) begin
            if (valid_reg[i] && (((entry_mem[i] ^ cur_img_reg) & kmask) == 80'h0)) begin
                c_hit = 1'b1;
                c_hit_idx = i[IDX_W-1:0];
            end
            if (!valid_reg[i]) begin
                c_free = 1'b1;
                c_free_idx = i[IDX_W-1:0];
                c_free_cnt = c_free_cnt + 1'b1;
            end
        end
    end

    // Arbitration between pending synchronous and host database operations.
    wire both_req   = sync_pend_reg && host_pend_reg;
    wire both_learn = both_req && (sync_op_reg == `OP_LEARN) && (host_op_reg == `OP_LEARN);
    wire exc_hit    = both_learn && (c_free_cnt == `EXC_FREE_LEFT);
    wire arb_ok     = (state_reg == ST_IDLE) && init_done;
    wire pick_sync  = arb_ok && sync_pend_reg && (!host_pend_reg || cfg_sync_priority);
    wire pick_host  = arb_ok && host_pend_reg && (!sync_pend_reg || !cfg_sync_priority);
    wire drop_sync  = arb_ok && exc_hit && !cfg_sync_priority;
    wire drop_host  = arb_ok && exc_hit && cfg_sync_priority;
    wire res_done   = (state_reg == ST_RES);
    wire host_done  = (res_done && cur_host_reg) || drop_host;
    wire sync_image_src = (sync_op_reg == `OP_LEARN);
    wire [79:0] sync_img = (cmp_buf_reg[79:0] & kmask) |
                           (({48'h0, sync_assoc_reg} << cw) & ~kmask & {48'h0, sync_image_src ? 32'hffff_ffff : 32'h0} << cw);
    wire sync_take  = stb_s && init_done && !sync_pend_reg;
    wire learn_ins  = res_done && (cur_op_reg == `OP_LEARN) && !hit_reg && free_any_reg && casc_s;

    // Database engine: take, compare, then commit the result.
    always @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            init_cnt_reg <= 10'h000;
            valid_reg <= {DEPTH{1'b0}};
            sync_pend_reg <= 1'b0;
            sync_op_reg <= 4'h0;
            sync_assoc_reg <= 32'h0;
            load_pos_reg <= 7'h00;
            cmp_buf_reg <= 112'h0;
            cur_host_reg <= 1'b0;
            cur_op_reg <= 4'h0;
            cur_img_reg <= 80'h0;
            hit_reg <= 1'b0;
            match_reg <= 1'b0;
            hit_idx_reg <= {IDX_W{1'b0}};
            free_idx_reg <= {IDX_W{1'b0}};
            free_any_reg <= 1'b0;
        end else begin
            if (!init_done)
                init_cnt_reg <= init_cnt_reg + 10'h001;
            if (sync_take && op_s == `OP_LOAD && load_pos_reg < `CMP_W_MAX) begin
                if (lane_wide)
                    cmp_buf_reg[load_pos_reg +: 32] <= din_s;
                else
                    cmp_buf_reg[load_pos_reg +: 16] <= din_s[15:0];
                load_pos_reg <= load_pos_reg + lane_w;
            end else if (sync_take && op_s != `OP_LOAD) begin
                sync_pend_reg <= 1'b1;
                sync_op_reg <= op_s;
                sync_assoc_reg <= lane_wide ? din_s : {16'h0, din_s[15:0]};
            end
            if (pick_sync || drop_sync) begin
                sync_pend_reg <= 1'b0;
                load_pos_reg <= 7'h00;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (pick_sync) begin
                        cur_host_reg <= 1'b0;
                        cur_op_reg <= sync_op_reg;
                        cur_img_reg <= sync_img;
                        state_reg <= ST_CMP;
                    end else if (pick_host) begin
                        cur_host_reg <= 1'b1;
                        cur_op_reg <= host_op_reg;
                        cur_img_reg <= {img2_reg[15:0], img1_reg, img0_reg};
                        state_reg <= ST_CMP;
                    end
                end
                ST_CMP: begin
                    hit_reg <= c_hit;
                    hit_idx_reg <= c_hit_idx;
                    free_idx_reg <= c_free_idx;
                    free_any_reg <= c_free;
                    state_reg <= ST_RES;
                end
                ST_RES: begin
                    if (cur_op_reg == `OP_SEARCH || cur_op_reg == `OP_LEARN)
                        match_reg <= hit_reg;
                    if (cur_op_reg == `OP_LEARN && hit_reg)
                        entry_mem[hit_idx_reg] <= cur_img_reg;
                    if (learn_ins) begin
                        entry_mem[free_idx_reg] <= cur_img_reg;
                        valid_reg[free_idx_reg] <= 1'b1;
                    end
                    if (cur_op_reg == `OP_AGE && hit_reg)
                        valid_reg[hit_idx_reg] <= 1'b0;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Result words leave through a stage register so the valid strobe can lead.
    wire adv_edge = adv_s && !adv_prev_reg;
    wire new_res  = res_done && !cur_host_reg && (cur_op_reg == `OP_SEARCH) && hit_reg;
    wire [2:0] pick_k = new_res ? 3'h0 : out_cnt_reg + 3'h1;
    wire [2:0] assoc_k = cfg_index_first ? pick_k - 3'h1 : pick_k;
    wire is_idx = cfg_index_first ? (pick_k == 3'h0) : (pick_k == n_assoc[2:0]);
    wire [79:0] assoc_src = new_res ? (entry_mem[hit_idx_reg] >> cw) : res_assoc_reg;
    wire [79:0] assoc_sh  = assoc_src >> (lane_wide ? {assoc_k, 5'h00} : {1'b0, assoc_k, 4'h0});
    wire [IDX_W-1:0] idx_src = new_res ? hit_idx_reg : res_idx_reg;
    wire [31:0] word_sel = is_idx ? {{(32-IDX_W){1'b0}}, idx_src} :
                           (lane_wide ? assoc_sh[31:0] : {16'h0, assoc_sh[15:0]});
    always @(posedge clk) begin
        if (reset) begin
            res_assoc_reg <= 80'h0;
            res_idx_reg <= {IDX_W{1'b0}};
            out_cnt_reg <= 3'h0;
            out_total_reg <= 3'h0;
            adv_prev_reg <= 1'b0;
            stage_reg <= 32'h0;
            stage_vld_reg <= 1'b0;
            dvld_reg <= 1'b0;
            dout <= 32'h0;
        end else begin
            adv_prev_reg <= adv_s;
            stage_vld_reg <= 1'b0;
            dvld_reg <= stage_vld_reg;
            if (new_res || (adv_edge && out_cnt_reg < out_total_reg)) begin
                stage_reg <= word_sel;
                stage_vld_reg <= 1'b1;
                out_cnt_reg <= pick_k;
            end
            if (new_res) begin
                res_assoc_reg <= entry_mem[hit_idx_reg] >> cw;
                res_idx_reg <= hit_idx_reg;
                out_total_reg <= n_assoc[2:0];
            end
            if (stage_vld_reg)
                dout <= stage_reg;
        end
    end
    // Lead mode shows valid while the word is still in the stage register.
    assign sync_out_valid_n = cfg_valid_lead ? ~stage_vld_reg : ~dvld_reg;
    assign dout_oe = oe_s;

    // Host port: a cycle is taken once per select assertion.
    wire       host_take = sel_s && !host_act_reg;
    wire [4:0] reg_idx   = addr_s[5:1];
    wire       half      = addr_s[0];
    wire       hwr       = host_take && !rw_s;
    wire       hrd       = host_take && rw_s;
    wire [31:0] rd_word  = (reg_idx == `REG_STATUS) ? {28'h0, init_done, state_reg == ST_IDLE,
                                                       ~full_flag_n, match_reg} :
                           (reg_idx == `REG_INDEX)  ? {28'h0, pend_int_reg} :
                           (reg_idx == `REG_FLAG_AQ) ? {24'h0, aq_cnt_reg} :
                           (reg_idx == `REG_FLAG_LQ) ? {24'h0, lq_cnt_reg} :
                           (reg_idx == `REG_IMG0) ? img0_reg :
                           (reg_idx == `REG_IMG1) ? img1_reg :
                           (reg_idx == `REG_IMG2) ? img2_reg :
                           (reg_idx == `REG_RESULT) ? {{(31-IDX_W){1'b0}}, hit_reg, hit_idx_reg} :
                           32'h0;
    wire [3:0] int_set = {drop_sync, drop_host,
                          lq_armed_reg && learn_ins,
                          aq_armed_reg && res_done && cur_op_reg == `OP_AGE && hit_reg};
    wire [3:0] int_clr = {hrd && reg_idx == `REG_FLAG_SYNC_WRITE_EXCEPTION, hrd && reg_idx == `REG_FLAG_HOST_WRITE_EXCEPTION,
                          hrd && reg_idx == `REG_FLAG_LQ, hrd && reg_idx == `REG_FLAG_AQ};
    wire clr_lq = res_done && cur_op_reg == `OP_CLR_LQ;
    wire clr_aq = res_done && cur_op_reg == `OP_CLR_AQ;
    always @(posedge clk) begin
        if (reset) begin
            host_act_reg <= 1'b0;
            host_cmd_wait_reg <= 1'b0;
            host_ack <= 1'b0;
            host_data_out <= 32'h0;
            host_pend_reg <= 1'b0;
            host_op_reg <= 4'h0;
            img0_reg <= 32'h0;
            img1_reg <= 32'h0;
            img2_reg <= 32'h0;
            lq_cnt_reg <= 8'h00;
            aq_cnt_reg <= 8'h00;
            lq_armed_reg <= 1'b1;
            aq_armed_reg <= 1'b1;
            pend_int_reg <= 4'h0;
            int_out <= 1'b0;
        end else begin
            if (host_take)
                host_act_reg <= 1'b1;
            else if (!sel_s)
                host_act_reg <= 1'b0;
            if (!sel_s)
                host_ack <= 1'b0;
            else if (host_take && !(hwr && reg_idx == `REG_CMD))
                host_ack <= 1'b1;
            else if (host_cmd_wait_reg && host_done)
                host_ack <= 1'b1;
            if (hrd)
                host_data_out <= (cfg_host_wide || !half) ? rd_word : {16'h0, rd_word[31:16]};
            if (hwr && reg_idx == `REG_IMG0)
                img0_reg <= merge_half(img0_reg, hdin_s, half, cfg_host_wide);
            if (hwr && reg_idx == `REG_IMG1)
                img1_reg <= merge_half(img1_reg, hdin_s, half, cfg_host_wide);
            if (hwr && reg_idx == `REG_IMG2)
                img2_reg <= merge_half(img2_reg, hdin_s, half, cfg_host_wide);
            if (hwr && reg_idx == `REG_CMD && !host_pend_reg) begin
                host_pend_reg <= 1'b1;
                host_op_reg <= hdin_s[3:0];
                host_cmd_wait_reg <= 1'b1;
            end else if (pick_host || drop_host) begin
                host_pend_reg <= 1'b0;
            end
            if (host_done)
                host_cmd_wait_reg <= 1'b0;
            // Queue counters; a queue interrupt rearms only after its queue empties.
            if (clr_lq)
                lq_cnt_reg <= 8'h00;
            else if (learn_ins && lq_cnt_reg != 8'hff)
                lq_cnt_reg <= lq_cnt_reg + 8'h01;
            if (clr_aq)
                aq_cnt_reg <= 8'h00;
            else if (int_set[`INT_AQ] || (res_done && cur_op_reg == `OP_AGE && hit_reg && aq_cnt_reg != 8'hff))
                aq_cnt_reg <= aq_cnt_reg + 8'h01;
            if (lq_cnt_reg == 8'h00 && !learn_ins)
                lq_armed_reg <= 1'b1;
            else if (learn_ins)
                lq_armed_reg <= 1'b0;
            if (aq_cnt_reg == 8'h00 && !(res_done && cur_op_reg == `OP_AGE && hit_reg))
                aq_armed_reg <= 1'b1;
            else if (res_done && cur_op_reg == `OP_AGE && hit_reg)
                aq_armed_reg <= 1'b0;
            // A new event in the acknowledge cycle stays pending.
            pend_int_reg <= int_set | (pend_int_reg & ~int_clr);
            int_out <= ((|(pend_int_reg & cfg_int_enable)) == cfg_int_active_high);
        end
    end
    assign host_data_oe = host_ack && rw_s && sel_s;

    assign sync_in_ready  = init_done && (state_reg == ST_IDLE) && !sync_pend_reg;
    assign match_flag_n   = ~match_reg;
    assign full_flag_n    = |(~valid_reg);
    // A device learns only once every device above it is full, so the chain needs no setup.
    assign cascade_up     = casc_s && ~full_flag_n;
    assign cascade_select = match_reg;
    assign cascade_bus    = {match_reg, ~full_flag_n, sync_in_ready, state_reg != ST_IDLE};
endmodule // cam_lookup_dual_port_interface
`default_nettype wire

// file: tb/cam_lookup_props.sv
`timescale 1ns/10ps
`default_nettype none
module cam_lookup_props (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [3:0]  cfg_int_enable,
    input wire logic        cfg_int_active_high,
    input wire logic        sync_in_ready,
    input wire logic [31:0] dout,
    input wire logic        dout_oe,
    input wire logic        out_enable_n,
    input wire logic        sync_out_valid_n,
    input wire logic        host_rw,
    input wire logic        host_select_n,
    input wire logic        host_data_oe,
    input wire logic        host_ack,
    input wire logic        match_flag_n,
    input wire logic        full_flag_n,
    input wire logic        int_out,
    input wire logic        cascade_up,
    input wire logic        cascade_select
);
    // Everything is watched on the one system clock.
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    reset_vals_a: assert property ($fell(reset) |-> !host_ack && sync_out_valid_n && match_flag_n && full_flag_n
        && !sync_in_ready && dout == 32'h0) else $error("outputs not at reset values");
    ready_rise_a: assert property ($fell(reset) |-> ##[1:801] sync_in_ready) else $error("input ready late");
    oe_on_a: assert property ($fell(out_enable_n) |-> ##[1:3] dout_oe) else $error("output not enabled");
    oe_off_a: assert property ($rose(out_enable_n) |-> ##[1:3] !dout_oe) else $error("output not released");
    // The host pins reach the drive logic through two flip-flops, so the pins are compared two clocks back.
    host_drive_a: assert property (host_data_oe == (host_ack && $past(host_rw, 2) && !$past(host_select_n, 2)))
        else $error("host data drive wrong");
    ack_drop_a: assert property (host_select_n [*4] |-> !host_ack) else $error("host ack held");
    valid_pulse_a: assert property (!sync_out_valid_n |=> sync_out_valid_n) else $error("valid too long");
    int_idle_a: assert property ($past(cfg_int_enable) == 4'h0 && !$past(reset) |-> int_out == !cfg_int_active_high)
        else $error("interrupt level wrong");
    match_sel_a: assert property (cascade_select == !match_flag_n) else $error("select not match");
    match_hold_a: assert property ($changed(match_flag_n) |-> !$past(sync_in_ready))
        else $error("match flag moved while idle");
    full_up_a: assert property (cascade_up |-> !full_flag_n) else $error("cascade up while not full");
endmodule // cam_lookup_props
bind cam_lookup_dual_port_interface cam_lookup_props u_props (.clk, .reset, .cfg_int_enable, .cfg_int_active_high,
    .sync_in_ready, .dout, .dout_oe, .out_enable_n, .sync_out_valid_n, .host_rw, .host_select_n, .host_data_oe,
    .host_ack, .match_flag_n, .full_flag_n, .int_out, .cascade_up, .cascade_select);
`default_nettype wire

// file: tb/host_cpu.sv
`timescale 1ns/10ps
`default_nettype none
module host_cpu (
    input  wire logic        clk,
    input  wire logic        host_ack,
    input  wire logic [31:0] host_data_out,
    output var  logic [5:0]  host_reg_addr,
    output var  logic        host_rw,
    output var  logic        host_select_n,
    output var  logic [31:0] host_data_in
);
    initial begin
        host_reg_addr = 6'h00;
        host_rw = 1'b1;
        host_select_n = 1'b1;
        host_data_in = 32'h0;
    end
    // One cycle; select stays low until ack, then the data lines show junk.
    task access(input logic [5:0] a, input logic rw, input logic [31:0] wd, output logic [31:0] rd);
        host_reg_addr = a;
        host_rw = rw;
        host_data_in = wd;
        host_select_n = 1'b0;
        while (host_ack !== 1'b1) @(negedge clk);
        rd = host_data_out;
        host_select_n = 1'b1;
        host_data_in = ~wd;
        repeat (3) @(negedge clk);
    endtask
endmodule // host_cpu
`default_nettype wire

// file: tb/tb_cam_lookup_dual_port_interface.sv
`timescale 1ns/10ps
`default_nettype none
`include "cam_lookup_map.vh"
module tb_cam_lookup_dual_port_interface;
    logic clk = 0, reset = 1, strb_n = 1, oe_n = 0, pri, pol, sel_n, rw, ack, oe_h, vld_n, mf_n, ff_n, rdy;
    logic [3:0]  op = 0, ien = 0;
    logic adv_n = 1, lead = 0, idx1 = 0, irq, vld_d = 0;
    logic [5:0]  addr;
    logic [31:0] din = 0, dout, hdi, hdo, seed = 32'h47, rd, key[8], asc[8];
    logic [31:0] exp_q[$];
    int n_mismatch = 0, check_count = 0, cyc = 0, n;
    // Clock at 40 ns.
    always #20 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    cam_lookup_dual_port_interface #(.READY_DELAY(10)) uut (.clk(clk), .reset(reset), .cfg_port_width(2'h3),
        .cfg_cmp_width(7'h30), .cfg_sync_priority(pri), .cfg_valid_lead(lead), .cfg_index_first(idx1),
        .cfg_host_wide(1'b1), .cfg_int_active_high(pol), .cfg_int_enable(ien), .din(din), .sync_in_strobe_n(strb_n),
        .opcode_in(op), .sync_in_ready(rdy), .dout(dout), .dout_oe(oe_h), .out_enable_n(oe_n),
        .sync_out_valid_n(vld_n), .sync_out_advance_n(adv_n), .host_reg_addr(addr), .host_rw(rw),
        .host_select_n(sel_n), .host_data_in(hdi), .host_data_out(hdo), .host_data_oe(), .host_ack(ack),
        .match_flag_n(mf_n), .full_flag_n(ff_n), .int_out(irq), .cascade_down(1'b1), .cascade_up(),
        .cascade_select(), .cascade_bus());
    host_cpu cpu (.clk(clk), .host_ack(ack), .host_data_out(hdo), .host_reg_addr(addr), .host_rw(rw),
        .host_select_n(sel_n), .host_data_in(hdi));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Waits for input ready, then strobes one request for a single clock.
    task sync_op(input logic [3:0] o, input logic [31:0] d);
        n = 0;
        while (rdy !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) n_mismatch++;
        din = d;
        op = o;
        strb_n = 1'b0;
        @(negedge clk);
        strb_n = 1'b1;
        // The shared bus carries the result lines between strobes.
        din = dout;
        repeat (8) @(negedge clk);
    endtask
    // A hit on entry 5 returns two words, the second one after a single advance pulse.
    task hit_search(input logic first_idx, input logic lead_mode);
        idx1 = first_idx;
        lead = lead_mode;
        exp_q.push_back(first_idx ? 32'h5 : asc[5]);
        exp_q.push_back(first_idx ? asc[5] : 32'h5);
        sync_op(`OP_LOAD, key[5]);
        sync_op(`OP_LOAD, {16'h0, asc[5][31:16]});
        sync_op(`OP_SEARCH, 32'h0);
        chk({31'h0, mf_n}, 32'h0);
        adv_n = 1'b0;
        @(negedge clk);
        adv_n = 1'b1;
        repeat (6) @(negedge clk);
        chk(exp_q.size(), 32'h0);
    endtask
    task final_report;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0 && exp_q.size() == 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Each output word is compared with the oldest expected word; in lead mode the word follows its strobe.
    always @(negedge clk) begin
        if (lead ? vld_d : vld_n === 1'b0) chk(dout, (exp_q.size() > 0) ? exp_q.pop_front() : ~dout);
        vld_d <= (vld_n === 1'b0);
    end
    // A hang is cut short well past the expected run length.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        pri = seed[0];
        pol = seed[1];
        repeat (12) @(negedge clk);
        reset = 1'b0;
        chk({31'h0, rdy}, 32'h0);
        // Fill every entry with a distinct 48-bit key and random data.
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            key[i] = {seed[31:3], i[2:0]};
            asc[i] = lfsr(seed);
            sync_op(`OP_LOAD, key[i]);
            sync_op(`OP_LOAD, {16'h0, asc[i][31:16]});
            sync_op(`OP_LEARN, asc[i]);
        end
        chk({31'h0, ff_n}, 32'h0);
        hit_search(1'b0, 1'b0);
        cpu.access({`REG_STATUS, 1'b0}, 1'b1, 32'h0, rd);
        chk({28'h0, rd[3:0]}, 32'hf);
        // Only the learned-queue source is enabled; the eight learns have left it pending.
        ien = 4'h2;
        repeat (2) @(negedge clk);
        chk({31'h0, irq}, {31'h0, pol});
        cpu.access({`REG_INDEX, 1'b0}, 1'b1, 32'h0, rd);
        chk(rd, 32'h2);
        cpu.access({`REG_FLAG_LQ, 1'b0}, 1'b1, 32'h0, rd);
        chk(rd, 32'h8);
        chk({31'h0, irq}, {31'h0, ~pol});
        oe_n = 1'b1;
        sync_op(`OP_LOAD, ~key[5]);
        sync_op(`OP_LOAD, {16'h0, asc[5][31:16]});
        sync_op(`OP_SEARCH, 32'h0);
        chk({31'h0, mf_n}, 32'h1);
        oe_n = 1'b0;
        hit_search(1'b1, 1'b1);
        repeat (5) @(negedge clk);
        final_report();
    end
endmodule // tb_cam_lookup_dual_port_interface
`default_nettype wire
